// ==== aaa_consts.vh ====
/*
 * constants for the accumulator add / and datapath.
 * assumes: included by bare name from the design files.
 */
`ifndef AAA_CONSTS_VH
`define AAA_CONSTS_VH

// ****************************************
// opcodes
// ****************************************
`define AAA_OP_W 3
`define AAA_OP_ADC_ACC 3'h0
`define AAA_OP_ADC_MEM 3'h1
`define AAA_OP_ADD_ACC 3'h2
`define AAA_OP_ADD_IMM 3'h3
`define AAA_OP_ADD_MEM 3'h4
`define AAA_OP_AND_ACC 3'h5
`define AAA_OP_AND_IMM 3'h6
`define AAA_OP_AND_MEM 3'h7

// ****************************************
// widths and reset values
// ****************************************
`define AAA_DW 8
`define AAA_MSB 7
`define AAA_NIB 4
`define AAA_ACC_RST 8'h00
`define AAA_ZERO 8'h00

// ****************************************
// axi4-lite map
// ****************************************
`define AAA_AXI_AW 4
`define AAA_OFS_ACC 4'h0
`define AAA_OFS_FLAGS 4'h4
`define AAA_OFS_CMD 4'h8
`define AAA_OFS_MEMRES 4'hC
`define AAA_RESP_OK 2'h0
`define AAA_RESP_ERR 2'h2

// flag bit positions in the flags register
`define AAA_FL_C 0
`define AAA_FL_HC 1
`define AAA_FL_Z 2
`define AAA_FL_SRE 3
`define AAA_FL_W 4
`define AAA_FL_RST 4'h0
`define AAA_STRB_B0 0

// command register fields
`define AAA_CMD_OP_LO 16
`define AAA_CMD_OP_HI 18
`define AAA_CMD_MEM_LO 0
`define AAA_CMD_MEM_HI 7
`define AAA_CMD_IMM_LO 8
`define AAA_CMD_IMM_HI 15

`endif

// ==== aaa_alu_core.v ====
/*
 * combinational 8-bit add / and unit with flag outputs.
 * assumes: operands stable within the cycle; caller registers the results.
 */
`include "aaa_consts.vh"

module aaa_alu_core (
  input wire [`AAA_DW-1:0] opa_i,
  input wire [`AAA_DW-1:0] opb_i,
  input wire carry_in_i,
  input wire use_and_i,
  output reg [`AAA_DW-1:0] result_o,
  output reg carry_o,
  output reg half_carry_o,
  output reg signed_range_error_o,
  output reg zero_o
);

  reg [`AAA_NIB:0] low_sum;
  reg [`AAA_DW:0] full_sum;

  // ****************************************
  // add / and
  // ****************************************
  always @* begin
    low_sum = {1'b0, opa_i[`AAA_NIB-1:0]} + {1'b0, opb_i[`AAA_NIB-1:0]}
      + {{`AAA_NIB{1'b0}}, carry_in_i};
    full_sum = {1'b0, opa_i} + {1'b0, opb_i} + {{`AAA_DW{1'b0}}, carry_in_i};
    if (use_and_i) begin
      result_o = opa_i & opb_i;
    end else begin
      result_o = full_sum[`AAA_DW-1:0];
    end
    carry_o = full_sum[`AAA_DW];
    half_carry_o = low_sum[`AAA_NIB];
    signed_range_error_o = (opa_i[`AAA_MSB] == opb_i[`AAA_MSB]) &&
      (full_sum[`AAA_MSB] != opa_i[`AAA_MSB]);
    zero_o = (result_o == `AAA_ZERO);
  end

endmodule

// ==== aaa_alu.v ====
/*
 * accumulator add / add-with-carry / and datapath with an axi4-lite slave.
 * map: 0x0 accumulator, 0x4 flags, 0x8 command (write only), 0xC memory result.
 * assumes: one clock, async active-low reset, data memory byte supplied by
 * software in the command word; memory results read back from a register.
 * ce_i low freezes every register, bus handshakes included.
 * writes to the memory result word or to unmapped words answer with an error.
 */
// The placing of the registers and register access over AXI4-Lite were left to the implementer.
// Operation
// - adc to accumulator: acc + mem + carry into acc, four flags updated
// - adc to memory: acc + mem + carry written to memory, acc kept
// - add memory: acc + mem without carry into acc, four flags updated
// - add immediate: acc + constant into acc, four flags updated
// - add to memory: acc + mem without carry into memory, four flags
// - and memory: acc and mem into acc, only zero flag
// - and immediate: acc and constant into acc, only zero flag
// - and to memory: mem and acc bitwise, result to memory
`include "aaa_consts.vh"

module aaa_alu (
  input wire clock_i,
  input wire arst_n_i,
  input wire ce_i,
  input wire [`AAA_AXI_AW-1:0] s_axi_awaddr_i,
  input wire s_axi_awvalid_i,
  output reg s_axi_awready_o,
  input wire [31:0] s_axi_wdata_i,
  input wire [3:0] s_axi_wstrb_i,
  input wire s_axi_wvalid_i,
  output reg s_axi_wready_o,
  output reg [1:0] s_axi_bresp_o,
  output reg s_axi_bvalid_o,
  input wire s_axi_bready_i,
  input wire [`AAA_AXI_AW-1:0] s_axi_araddr_i,
  input wire s_axi_arvalid_i,
  output reg s_axi_arready_o,
  output reg [31:0] s_axi_rdata_o,
  output reg [1:0] s_axi_rresp_o,
  output reg s_axi_rvalid_o,
  input wire s_axi_rready_i,
  output reg [`AAA_DW-1:0] acc_o,
  output reg [`AAA_FL_W-1:0] flags_o,
  output reg [`AAA_DW-1:0] mem_result_o,
  output reg mem_write_o
);

  // ****************************************
  // decode helpers
  // ****************************************
  function is_known;
    input [`AAA_AXI_AW-1:0] a;
    begin
      is_known = (a == `AAA_OFS_ACC) || (a == `AAA_OFS_FLAGS) ||
        (a == `AAA_OFS_CMD) || (a == `AAA_OFS_MEMRES);
    end
  endfunction

  function is_writable;
    input [`AAA_AXI_AW-1:0] a;
    begin
      is_writable = (a == `AAA_OFS_ACC) || (a == `AAA_OFS_FLAGS) ||
        (a == `AAA_OFS_CMD);
    end
  endfunction

  function hits;
    input [`AAA_AXI_AW-1:0] a;
    input [`AAA_AXI_AW-1:0] ofs;
    input [3:0] s;
    begin
      hits = (a == ofs) && s[`AAA_STRB_B0];
    end
  endfunction

  // ****************************************
  // write channel capture
  // ****************************************
  reg aw_held;
  reg w_held;
  reg [`AAA_AXI_AW-1:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  wire aw_take = s_axi_awvalid_i && s_axi_awready_o;
  wire w_take = s_axi_wvalid_i && s_axi_wready_o;
  wire have_aw = aw_held || aw_take;
  wire have_w = w_held || w_take;
  wire [`AAA_AXI_AW-1:0] cur_aw = aw_held ? aw_addr : s_axi_awaddr_i;
  wire [31:0] cur_w = w_held ? w_data : s_axi_wdata_i;
  wire [3:0] cur_s = w_held ? w_strb : s_axi_wstrb_i;
  wire do_write = have_aw && have_w && !s_axi_bvalid_o;

  // ****************************************
  // operation decode
  // ****************************************
  wire [`AAA_OP_W-1:0] op = cur_w[`AAA_CMD_OP_HI:`AAA_CMD_OP_LO];
  wire [`AAA_DW-1:0] mem_byte = cur_w[`AAA_CMD_MEM_HI:`AAA_CMD_MEM_LO];
  wire [`AAA_DW-1:0] imm_byte = cur_w[`AAA_CMD_IMM_HI:`AAA_CMD_IMM_LO];
  wire cmd_full = cur_s[0] && cur_s[1] && cur_s[2];
  wire do_cmd = do_write && (cur_aw == `AAA_OFS_CMD) && cmd_full;

  reg [`AAA_DW-1:0] opb;
  reg cin;
  reg use_and;
  reg to_mem;
  reg arith;

  always @* begin
    opb = mem_byte;
    cin = 1'b0;
    use_and = 1'b0;
    to_mem = 1'b0;
    arith = 1'b1;
    case (op)
      `AAA_OP_ADC_ACC: begin
        cin = flags_o[`AAA_FL_C];
      end
      `AAA_OP_ADC_MEM: begin
        cin = flags_o[`AAA_FL_C];
        to_mem = 1'b1;
      end
      `AAA_OP_ADD_ACC: begin
        cin = 1'b0;
      end
      `AAA_OP_ADD_IMM: begin
        opb = imm_byte;
      end
      `AAA_OP_ADD_MEM: begin
        to_mem = 1'b1;
      end
      `AAA_OP_AND_ACC: begin
        use_and = 1'b1;
        arith = 1'b0;
      end
      `AAA_OP_AND_IMM: begin
        opb = imm_byte;
        use_and = 1'b1;
        arith = 1'b0;
      end
      `AAA_OP_AND_MEM: begin
        use_and = 1'b1;
        arith = 1'b0;
        to_mem = 1'b1;
      end
      default: begin
        arith = 1'b1;
      end
    endcase
  end

  wire [`AAA_DW-1:0] alu_res;
  wire alu_c;
  wire alu_hc;
  wire alu_sre;
  wire alu_z;

  aaa_alu_core u_core (
    .opa_i(acc_o),
    .opb_i(opb),
    .carry_in_i(cin),
    .use_and_i(use_and),
    .result_o(alu_res),
    .carry_o(alu_c),
    .half_carry_o(alu_hc),
    .signed_range_error_o(alu_sre),
    .zero_o(alu_z)
  );

  // ****************************************
  // datapath state
  // ****************************************
  wire acc_load = do_write && hits(cur_aw, `AAA_OFS_ACC, cur_s);
  wire flags_load = do_write && hits(cur_aw, `AAA_OFS_FLAGS, cur_s);

  reg [`AAA_FL_W-1:0] next_flags;
  reg [`AAA_DW-1:0] next_acc;
  reg [`AAA_DW-1:0] next_mem_result;
  reg next_mem_write;

  always @* begin
    next_flags = flags_o;
    next_acc = acc_o;
    next_mem_result = mem_result_o;
    next_mem_write = 1'b0;
    if (do_cmd) begin
      next_flags[`AAA_FL_Z] = alu_z;
      if (arith) begin
        next_flags[`AAA_FL_C] = alu_c;
        next_flags[`AAA_FL_HC] = alu_hc;
        next_flags[`AAA_FL_SRE] = alu_sre;
      end
      if (to_mem) begin
        next_mem_result = alu_res;
        next_mem_write = 1'b1;
      end else begin
        next_acc = alu_res;
      end
    end else if (acc_load) begin
      next_acc = cur_w[`AAA_DW-1:0];
    end else if (flags_load) begin
      next_flags = cur_w[`AAA_FL_W-1:0];
    end
  end

  // ****************************************
  // datapath registers
  // ****************************************
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      acc_o <= `AAA_ACC_RST;
      flags_o <= `AAA_FL_RST;
      mem_result_o <= `AAA_ZERO;
      mem_write_o <= 1'b0;
    end else if (ce_i) begin
      acc_o <= next_acc;
      flags_o <= next_flags;
      mem_result_o <= next_mem_result;
      mem_write_o <= next_mem_write;
    end
  end

  // ****************************************
  // axi write handshake
  // ****************************************
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= `AAA_OFS_ACC;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o <= 1'b0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `AAA_RESP_OK;
    end else if (ce_i) begin
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= is_writable(cur_aw) ? `AAA_RESP_OK : `AAA_RESP_ERR;
        s_axi_awready_o <= 1'b0;
        s_axi_wready_o <= 1'b0;
      end else begin
        if (aw_take) begin
          aw_held <= 1'b1;
          aw_addr <= s_axi_awaddr_i;
        end
        if (w_take) begin
          w_held <= 1'b1;
          w_data <= s_axi_wdata_i;
          w_strb <= s_axi_wstrb_i;
        end
        if (s_axi_bvalid_o && s_axi_bready_i) begin
          s_axi_bvalid_o <= 1'b0;
        end
        s_axi_awready_o <= !s_axi_bvalid_o && !have_aw && !s_axi_awready_o;
        s_axi_wready_o <= !s_axi_bvalid_o && !have_w && !s_axi_wready_o;
      end
    end
  end

  // ****************************************
  // read data select
  // ****************************************
  reg [31:0] next_rdata;
  reg [1:0] next_rresp;

  always @* begin
    next_rresp = is_known(s_axi_araddr_i) ? `AAA_RESP_OK : `AAA_RESP_ERR;
    case (s_axi_araddr_i)
      `AAA_OFS_ACC: next_rdata = {24'h000000, acc_o};
      `AAA_OFS_FLAGS: next_rdata = {28'h0000000, flags_o};
      `AAA_OFS_MEMRES: next_rdata = {24'h000000, mem_result_o};
      default: next_rdata = 32'h00000000;
    endcase
  end

  // ****************************************
  // axi read channel
  // ****************************************
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h00000000;
      s_axi_rresp_o <= `AAA_RESP_OK;
    end else if (ce_i) begin
      if (s_axi_arvalid_i && s_axi_arready_o) begin
        s_axi_arready_o <= 1'b0;
        s_axi_rvalid_o <= 1'b1;
        s_axi_rresp_o <= next_rresp;
        s_axi_rdata_o <= next_rdata;
      end else begin
        if (s_axi_rvalid_o && s_axi_rready_i) begin
          s_axi_rvalid_o <= 1'b0;
        end
        s_axi_arready_o <= !s_axi_rvalid_o && !s_axi_arready_o &&
          s_axi_arvalid_i;
      end
    end
  end

endmodule

// ==== aaa_alu_asserts.sv ====
/* checker for aaa_alu bus handshakes and datapath results.
   assumes: bound to aaa_alu, ce_i held high. */
module aaa_alu_asserts (
  input logic clock_i,
  input logic arst_n_i,
  input logic ce_i,
  input logic [3:0] s_axi_awaddr_i,
  input logic s_axi_awvalid_i,
  input logic s_axi_awready_o,
  input logic [31:0] s_axi_wdata_i,
  input logic [3:0] s_axi_wstrb_i,
  input logic s_axi_wvalid_i,
  input logic s_axi_wready_o,
  input logic s_axi_bvalid_o,
  input logic s_axi_arvalid_i,
  input logic s_axi_arready_o,
  input logic [31:0] s_axi_rdata_o,
  input logic [1:0] s_axi_rresp_o,
  input logic s_axi_rvalid_o,
  input logic s_axi_rready_i,
  input logic [7:0] acc_o,
  input logic [3:0] flags_o,
  input logic mem_write_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****
  // properties
  // ****
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  wire aw = s_axi_awvalid_i && s_axi_awready_o;
  wire w = s_axi_wvalid_i && s_axi_wready_o;
  wire cmd = ce_i && aw && w && s_axi_awaddr_i == 4'h8 && s_axi_wstrb_i[2:0] == 3'h7;
  wire [2:0] op = s_axi_wdata_i[18:16];
  property p_b;
    aw && w |=> s_axi_bvalid_o;
  endproperty
  a_b: assert property (p_b) else $error("no write response");
  property p_rv;
    s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o;
  endproperty
  a_rv: assert property (p_rv) else $error("no read data");
  property p_rh;
    s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o);
  endproperty
  a_rh: assert property (p_rh) else $error("read data dropped");
  property p_mw;
    mem_write_o |-> $rose(s_axi_bvalid_o);
  endproperty
  a_mw: assert property (p_mw) else $error("stray memory write");
  property p_mp;
    cmd && (op == 3'h1 || op == 3'h4 || op == 3'h7) |=> mem_write_o && $stable(acc_o);
  endproperty
  a_mp: assert property (p_mp) else $error("memory op bad");
  property p_kf;
    cmd && op > 3'h4 |=> (flags_o & 4'hB) == ($past(flags_o) & 4'hB);
  endproperty
  a_kf: assert property (p_kf) else $error("and op moved flags");
  property p_ai;
    cmd && op == 3'h3 |=> acc_o == 8'($past(acc_o) + $past(s_axi_wdata_i[15:8]));
  endproperty
  a_ai: assert property (p_ai) else $error("add imm wrong");
  property p_z;
    cmd && op == 3'h6 |=> flags_o[2] == (($past(acc_o) & $past(s_axi_wdata_i[15:8])) == 8'h00);
  endproperty
  a_z: assert property (p_z) else $error("zero flag wrong");
  cover property (cmd && op == 3'h1);
  cover property (mem_write_o);
  cover property (s_axi_rvalid_o && s_axi_rresp_o == 2'h2);
endmodule

bind aaa_alu aaa_alu_asserts aaa_alu_asserts_inst (.clock_i, .arst_n_i, .ce_i,
  .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i,
  .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bvalid_o, .s_axi_arvalid_i, .s_axi_arready_o,
  .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .acc_o, .flags_o,
  .mem_write_o);

// ==== aaa_alu_bench.sv ====
/* self-checking bench for aaa_alu over its axi4-lite port.
   assumes: aaa_alu and its checker compiled before this file. */
module aaa_alu_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock_i = 1'h0;
  logic arst_n = 1'h0;
  logic [3:0] awa = 4'h0, ara = 4'h0;
  logic [31:0] wd = 32'h0, rd, x = 32'hA112D0C2;
  logic awv = 1'h0, wv = 1'h0, bry = 1'h0, arv = 1'h0, rry = 1'h0;
  logic awr, wrd, bv, arr, rv, mw;
  logic [7:0] ao, mo;
  logic [3:0] fo;
  logic [3:0] ws = 4'hF;
  logic [1:0] bre, rre;
  logic [7:0] ma = 8'h00, mm = 8'h00;
  logic [3:0] mf = 4'h0;
  logic [13:0] qb[$];
  logic [7:0] qm[$];
  logic [33:0] qr[$];
  int errors = 0, n_checks = 0, k;
  always #4 clock_i = ~clock_i;
  aaa_alu aaa_alu_inst (.clock_i(clock_i), .arst_n_i(arst_n), .ce_i(1'h1),
    .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
    .s_axi_wdata_i(wd), .s_axi_wstrb_i(ws), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrd),
    .s_axi_bresp_o(bre), .s_axi_bvalid_o(bv), .s_axi_bready_i(bry),
    .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
    .s_axi_rdata_o(rd), .s_axi_rresp_o(rre), .s_axi_rvalid_o(rv), .s_axi_rready_i(rry),
    .acc_o(ao), .flags_o(fo), .mem_result_o(mo), .mem_write_o(mw));
  // ****
  // tasks
  // ****
  task end_sim;
    begin
      errors += qb.size() + qr.size() + qm.size();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
    end
  endtask
  task chk(input logic [33:0] s, input logic [33:0] e);
    begin
      n_checks++;
      if (s !== e) begin
        errors++;
        $display("[FAIL] %0t got %h exp %h", $time, s, e);
      end
    end
  endtask
  task tick(inout int n);
    begin
      @(posedge clock_i);
      n++;
      if (n > 100) begin
        errors++;
        end_sim;
      end
    end
  endtask
  function automatic logic [31:0] xs();
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    logic ta, tw;
    begin
      n = 0;
      ta = 1'h0;
      tw = 1'h0;
      qb.push_back({r, ma, mf});
      awa <= a;
      wd <= d;
      awv <= 1'h1;
      wv <= 1'h1;
      bry <= 1'h1;
      do begin
        tick(n);
        ta |= awr;
        tw |= wrd;
        if (awr) awv <= 1'h0;
        if (wrd) wv <= 1'h0;
      end while (!(ta && tw));
      while (!bv) tick(n);
      bry <= 1'h0;
      @(posedge clock_i);
    end
  endtask
  task rd_(input logic [3:0] a, input logic [33:0] e);
    int n;
    begin
      n = 0;
      qr.push_back(e);
      ara <= a;
      arv <= 1'h1;
      rry <= 1'h1;
      do tick(n); while (!arr);
      arv <= 1'h0;
      do tick(n); while (!rv);
      rry <= 1'h0;
      @(posedge clock_i);
    end
  endtask
  task op(input logic [2:0] o, input logic [7:0] m, input logic [7:0] i);
    logic [7:0] b, r;
    logic [8:0] s;
    logic [4:0] h;
    logic ci;
    begin
      b = (o == 3'h3 || o == 3'h6) ? i : m;
      ci = (o < 3'h2) & mf[0];
      s = ma + b + ci;
      h = ma[3:0] + b[3:0] + ci;
      r = (o > 3'h4) ? (ma & b) : s[7:0];
      if (o < 3'h5) mf = {ma[7] == b[7] && r[7] != ma[7], 1'h0, h[4], s[8]};
      mf[2] = (r == 8'h00);
      if (o == 3'h1 || o == 3'h4 || o == 3'h7) begin
        mm = r;
        qm.push_back(r);
      end else ma = r;
      wr(4'h8, {13'h0, o, i, m}, 2'h0);
      rd_(4'h0, {26'h0, ma});
      rd_(4'h4, {30'h0, mf});
      rd_(4'hC, {26'h0, mm});
    end
  endtask
  // ****
  // checking and stimulus
  // ****
  always @(posedge clock_i) if (rv && rry) chk({rre, rd}, qr.pop_front());
  always @(posedge clock_i) if (bv && bry) chk({20'h0, bre, ao, fo}, {20'h0, qb.pop_front()});
  always @(posedge clock_i) if (mw) chk({26'h0, mo}, {26'h0, qm.pop_front()});
  initial begin
    repeat (2) @(posedge clock_i);
    arst_n <= 1'h1;
    @(posedge clock_i);
    rd_(4'h0, 34'h0);
    rd_(4'h4, 34'h0);
    wr(4'hC, 32'h55, 2'h2);
    rd_(4'h2, {2'h2, 32'h0});
    rd_(4'h8, 34'h0);
    ws <= 4'h3;
    wr(4'h8, 32'h000300FF, 2'h0);
    ws <= 4'hF;
    for (k = 0; k < 64; k++) begin
      if (k % 8 == 0) begin
        x = xs();
        ma = x[7:0];
        wr(4'h0, {24'h0, ma}, 2'h0);
        mf = x[11:8];
        wr(4'h4, {28'h0, mf}, 2'h0);
      end
      x = xs();
      op(k[2:0], x[7:0], x[15:8]);
    end
    end_sim;
  end
endmodule
